// file: logic/i2c_rx_pkg.sv
// Purpose: shared constants and types of the i2c receive and start block
// Assumes: sys_clk at 50 MHz; link side runs on the module bit clock
// Notes:   counts derived from times round up to whole sys_clk cycles
package i2c_rx_pkg;
   // system clock period and bus free times
   localparam int SYS_PERIOD_NS  = 20;
   localparam int T_BUF_STD_NS   = 4700;
   localparam int T_BUF_FAST_NS  = 1300;
   localparam int TBUF_STD_INT   = (T_BUF_STD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int TBUF_FAST_INT  = (T_BUF_FAST_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [8:0] TBUF_STD_CYC  = 9'(TBUF_STD_INT);
   localparam logic [8:0] TBUF_FAST_CYC = 9'(TBUF_FAST_INT);

   // byte framing on the two-wire link
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [7:0] START_HOLD_CYC = 8'h04;   // bit clocks sda low before scl low

   // uart receive framing: start bit index 0, stop bit index 9
   localparam logic [3:0] UART_STOP_IDX = 4'h9;
   localparam int UART_BIT_CYC_DEF = 434;

   // link engine states, one-hot
   typedef enum logic [5:0] {
      L_IDLE = 6'h01,
      L_BITS = 6'h02,
      L_WAIT = 6'h04,
      L_ACK  = 6'h08,
      L_GEN  = 6'h10,
      L_OWN  = 6'h20
   } link_state_t;
endpackage

// file: logic/i2c_rx_link_if.sv
// Purpose: carrier between the register side and the bit clock link engine
// Assumes: every signal is a flop output of its sending domain
// Notes:   events travel as toggles, levels are synchronised by the receiver
`timescale 1ns/1ps
interface i2c_rx_link_if;
   logic       byte_tgl;
   logic [7:0] byte_data;
   logic       busy;
   logic       scl_low;
   logic       done_tgl;
   logic       take_tgl;
   logic       start_tgl;
   logic       abort;
   logic       run;

   modport sys_side (
      input  byte_tgl, byte_data, busy, scl_low, done_tgl,
      output take_tgl, start_tgl, abort, run
   );
   modport link_side (
      output byte_tgl, byte_data, busy, scl_low, done_tgl,
      input  take_tgl, start_tgl, abort, run
   );
endinterface

// file: logic/i2c_rx_link.sv
// Purpose: bit clock engine: pin sampling, byte shift, ack, stretch, start
// Assumes: run from the register side doubles as this domain's reset
// Notes:   the address phase after an own start is handled elsewhere
`timescale 1ns/1ps
module i2c_rx_link (
   // link clock
   input  wire logic bit_clk,
   // carrier to the register side
   i2c_rx_link_if.link_side lk,
   // two-wire pins, open drain
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      scl_oe_n,
   output logic      sda_oe_n,
   output logic      pin_low
);
   typedef struct packed {
      logic [1:0]              scl_s;
      logic [1:0]              sda_s;
      logic [1:0]              run_s;
      logic [1:0]              take_s;
      logic [1:0]              start_s;
      logic [1:0]              abort_s;
      logic                    scl_p;
      logic                    sda_p;
      i2c_rx_pkg::link_state_t st;
      logic [3:0]              cnt;
      logic [7:0]              sh;
      logic [7:0]              hold;
      logic                    byte_tgl;
      logic                    take_seen;
      logic                    start_seen;
      logic                    done_tgl;
      logic                    busy;
      logic                    nack;
      logic                    scl_oe_n;
      logic                    sda_oe_n;
      logic                    pin_low;
   } link_reg_t;

   link_reg_t state_ff;
   link_reg_t nxt_state;
   logic      scl_rise;
   logic      scl_fall;
   logic      start_cond;
   logic      stop_cond;
   logic      take_new;
   logic      start_new;

   // edge and condition decode on second sync stage only
   assign scl_rise   = state_ff.scl_s[1] & ~state_ff.scl_p;
   assign scl_fall   = ~state_ff.scl_s[1] & state_ff.scl_p;
   assign start_cond = state_ff.scl_s[1] & state_ff.scl_p & state_ff.sda_p & ~state_ff.sda_s[1];
   assign stop_cond  = state_ff.scl_s[1] & state_ff.scl_p & ~state_ff.sda_p & state_ff.sda_s[1];
   assign take_new   = state_ff.take_s[1] ^ state_ff.take_seen;
   assign start_new  = state_ff.start_s[1] ^ state_ff.start_seen;

   // next state of the whole engine
   always_comb begin
      nxt_state = state_ff;
      nxt_state.scl_s   = {state_ff.scl_s[0], scl_in};
      nxt_state.sda_s   = {state_ff.sda_s[0], sda_in};
      nxt_state.run_s   = {state_ff.run_s[0], lk.run};
      nxt_state.take_s  = {state_ff.take_s[0], lk.take_tgl};
      nxt_state.start_s = {state_ff.start_s[0], lk.start_tgl};
      nxt_state.abort_s = {state_ff.abort_s[0], lk.abort};
      nxt_state.scl_p   = state_ff.scl_s[1];
      nxt_state.sda_p   = state_ff.sda_s[1];
      nxt_state.pin_low = 1'b0;
      if (start_cond) begin
         nxt_state.busy = 1'b1;
      end
      if (stop_cond) begin
         nxt_state.busy = 1'b0;
      end
      case (state_ff.st)
         i2c_rx_pkg::L_IDLE: begin
            if (start_cond) begin
               nxt_state.st  = i2c_rx_pkg::L_BITS;
               nxt_state.cnt = 4'h0;
            end else if (start_new && !state_ff.busy) begin
               nxt_state.start_seen = state_ff.start_s[1];
               nxt_state.sda_oe_n   = 1'b0;
               nxt_state.hold       = 8'h00;
               nxt_state.st         = i2c_rx_pkg::L_GEN;
            end
         end
         i2c_rx_pkg::L_GEN: begin
            nxt_state.hold = state_ff.hold + 8'h01;
            if (state_ff.hold == i2c_rx_pkg::START_HOLD_CYC - 8'h01) begin
               nxt_state.scl_oe_n = 1'b0;
               nxt_state.done_tgl = ~state_ff.done_tgl;
               nxt_state.st       = i2c_rx_pkg::L_OWN;
            end
         end
         i2c_rx_pkg::L_OWN: begin
            nxt_state.st = i2c_rx_pkg::L_OWN;   // bus held until soft reset
         end
         i2c_rx_pkg::L_BITS: begin
            if (start_cond) begin
               nxt_state.cnt = 4'h0;
            end else if (stop_cond) begin
               nxt_state.st = i2c_rx_pkg::L_IDLE;
            end else if (scl_rise && state_ff.cnt != i2c_rx_pkg::BIT_CNT_FULL) begin
               nxt_state.sh  = {state_ff.sh[6:0], state_ff.sda_s[1]};
               nxt_state.cnt = state_ff.cnt + 4'h1;
            end else if (scl_fall && state_ff.cnt == i2c_rx_pkg::BIT_CNT_FULL) begin
               nxt_state.byte_tgl = ~state_ff.byte_tgl;
               nxt_state.scl_oe_n = 1'b0;
               nxt_state.st       = i2c_rx_pkg::L_WAIT;
            end
         end
         i2c_rx_pkg::L_WAIT: begin
            if (state_ff.abort_s[1]) begin
               nxt_state.scl_oe_n = 1'b1;
               nxt_state.nack     = 1'b1;
               nxt_state.st       = i2c_rx_pkg::L_ACK;
            end else if (take_new) begin
               nxt_state.take_seen = state_ff.take_s[1];
               nxt_state.sda_oe_n  = 1'b0;
               nxt_state.scl_oe_n  = 1'b1;
               nxt_state.nack      = 1'b0;
               nxt_state.st        = i2c_rx_pkg::L_ACK;
            end
         end
         i2c_rx_pkg::L_ACK: begin
            if (scl_fall) begin
               nxt_state.sda_oe_n = 1'b1;
               nxt_state.cnt      = 4'h0;
               nxt_state.st = state_ff.nack ? i2c_rx_pkg::L_IDLE : i2c_rx_pkg::L_BITS;
            end
         end
         default: begin
            nxt_state.st = i2c_rx_pkg::L_IDLE;
         end
      endcase
      if (!state_ff.run_s[1]) begin
         nxt_state.st         = i2c_rx_pkg::L_IDLE;
         nxt_state.cnt        = 4'h0;
         nxt_state.sh         = 8'h00;
         nxt_state.hold       = 8'h00;
         nxt_state.byte_tgl   = 1'b0;
         nxt_state.done_tgl   = 1'b0;
         nxt_state.take_seen  = state_ff.take_s[1];
         nxt_state.start_seen = state_ff.start_s[1];
         nxt_state.busy       = 1'b0;
         nxt_state.nack       = 1'b0;
         nxt_state.scl_oe_n   = 1'b1;
         nxt_state.sda_oe_n   = 1'b1;
      end
   end

   // single register bank of the link domain
   always_ff @(posedge bit_clk) begin
      state_ff <= nxt_state;
   end

   // carrier and pin outputs, all flops
   assign lk.byte_tgl  = state_ff.byte_tgl;
   assign lk.byte_data = state_ff.sh;
   assign lk.busy      = state_ff.busy;
   assign lk.scl_low   = ~state_ff.scl_s[1];
   assign lk.done_tgl  = state_ff.done_tgl;
   assign scl_oe_n     = state_ff.scl_oe_n;
   assign sda_oe_n     = state_ff.sda_oe_n;
   assign pin_low      = state_ff.pin_low;

   wait_stretch_a: assert property (@(posedge bit_clk) disable iff (!state_ff.run_s[1])
      state_ff.st == i2c_rx_pkg::L_WAIT |-> !scl_oe_n && sda_oe_n)
      else $error("clock not stretched while byte waits");
   ack_drive_a: assert property (@(posedge bit_clk) disable iff (!state_ff.run_s[1])
      state_ff.st == i2c_rx_pkg::L_WAIT && take_new && !state_ff.abort_s[1]
      |=> state_ff.st == i2c_rx_pkg::L_ACK && !sda_oe_n && scl_oe_n)
      else $error("buffered byte not acknowledged");
   nack_abort_a: assert property (@(posedge bit_clk) disable iff (!state_ff.run_s[1])
      state_ff.st == i2c_rx_pkg::L_WAIT && state_ff.abort_s[1]
      |=> sda_oe_n && state_ff.nack ##1 state_ff.st != i2c_rx_pkg::L_BITS)
      else $error("aborted byte not nacked");
   start_hold_a: assert property (@(posedge bit_clk) disable iff (!state_ff.run_s[1])
      state_ff.st == i2c_rx_pkg::L_IDLE && start_new && state_ff.busy && !start_cond
      |=> sda_oe_n && state_ff.st != i2c_rx_pkg::L_GEN)
      else $error("start driven on busy bus");
   byte_post_a: assert property (@(posedge bit_clk) disable iff (!state_ff.run_s[1])
      state_ff.st == i2c_rx_pkg::L_BITS && scl_fall && !start_cond && !stop_cond
      && state_ff.cnt == i2c_rx_pkg::BIT_CNT_FULL
      |=> $changed(state_ff.byte_tgl) && state_ff.st == i2c_rx_pkg::L_WAIT)
      else $error("completed byte not posted");
   nack_cov_c: cover property (@(posedge bit_clk) disable iff (!state_ff.run_s[1])
      state_ff.st == i2c_rx_pkg::L_ACK && state_ff.nack);
endmodule

// file: logic/i2c_rx_ctrl.sv
// Purpose: register side of the i2c receiver with start request and uart receive status
// Assumes: software strobes come from logic on sys_clk; pins and link flags are async
// Notes:   the shift register and the receive buffer give two byte stages;
//          reset_n must stay low for at least four bit_clk periods
`timescale 1ns/1ps
// Summary of operation
// - buffer one byte while next shifts in
// - ack byte when moved into buffer
// - reading buffer frees it
// - reads at any time never disturb bus
// - aborted slave reception answers with nack
// - receive flag shows byte in buffer
// - status shows clock line held low
// - start request waits for bus release
// - keep bus free time before start
// - uart busy while byte is received
module i2c_rx_ctrl #(
   parameter int UART_BIT_CYC = i2c_rx_pkg::UART_BIT_CYC_DEF
) (
   // system clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // link clock
   input  wire logic       bit_clk,
   // software control
   input  wire logic       soft_reset_bit,
   input  wire logic       start_set,
   input  wire logic       fast_mode,
   input  wire logic       slave_abort,
   input  wire logic       rx_read,
   // software status
   output logic [7:0]      i2c_rx_buffer,
   output logic            i2c_rx_flag,
   output logic            scl_low_flag,
   output logic            bus_busy_flag,
   output logic            start_request,
   output logic            uart_busy_flag,
   output logic            uart_frame_error,
   // two-wire pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            sda_out,
   output logic            scl_oe_n,
   output logic            sda_oe_n,
   // uart receive pin
   input  wire logic       uart_rxd
);
   typedef struct packed {
      logic        run;
      logic [1:0]  byte_s;
      logic        byte_seen;
      logic [1:0]  busy_s;
      logic [1:0]  scll_s;
      logic [1:0]  done_s;
      logic        done_seen;
      logic        take_tgl;
      logic        start_tgl;
      logic        launched;
      logic        start_req;
      logic [8:0]  tbuf_cnt;
      logic        pending;
      logic [7:0]  buf_q;
      logic        buf_full;
      logic        abort;
      logic [1:0]  uart_s;
      logic        ubusy;
      logic        uframe_err;
      logic [15:0] ucnt;
      logic [3:0]  ubits;
   } sys_reg_t;

   sys_reg_t   state_ff;
   sys_reg_t   nxt_state;
   logic       byte_new;
   logic       done_new;
   logic [8:0] tbuf_lim;
   logic       pin_low;

   i2c_rx_link_if lk ();

   // link engine on the bit clock
   i2c_rx_link u_link (
      .bit_clk  (bit_clk),
      .lk       (lk.link_side),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .scl_oe_n (scl_oe_n),
      .sda_oe_n (sda_oe_n),
      .pin_low  (pin_low)
   );

   // toggle edges seen after the two sync stages
   assign byte_new = state_ff.byte_s[1] ^ state_ff.byte_seen;
   assign done_new = state_ff.done_s[1] ^ state_ff.done_seen;
   assign tbuf_lim = fast_mode ? i2c_rx_pkg::TBUF_FAST_CYC : i2c_rx_pkg::TBUF_STD_CYC;

   // next state of the register side
   always_comb begin
      nxt_state = state_ff;
      nxt_state.run    = ~soft_reset_bit;
      nxt_state.abort  = slave_abort;
      nxt_state.byte_s = {state_ff.byte_s[0], lk.byte_tgl};
      nxt_state.busy_s = {state_ff.busy_s[0], lk.busy};
      nxt_state.scll_s = {state_ff.scll_s[0], lk.scl_low};
      nxt_state.done_s = {state_ff.done_s[0], lk.done_tgl};
      nxt_state.uart_s = {state_ff.uart_s[0], uart_rxd};
      if (!state_ff.run) begin
         nxt_state.byte_seen  = state_ff.byte_s[1];
         nxt_state.done_seen  = state_ff.done_s[1];
         nxt_state.pending    = 1'b0;
         nxt_state.buf_full   = 1'b0;
         nxt_state.start_req  = 1'b0;
         nxt_state.launched   = 1'b0;
         nxt_state.tbuf_cnt   = 9'h000;
         nxt_state.ubusy      = 1'b0;
         nxt_state.uframe_err = 1'b0;
         nxt_state.ucnt       = 16'h0000;
         nxt_state.ubits      = 4'h0;
      end else begin
         if (rx_read) begin
            nxt_state.buf_full = 1'b0;
         end
         if (byte_new) begin
            nxt_state.byte_seen = state_ff.byte_s[1];
            nxt_state.pending   = 1'b1;
         end
         // move byte when buffer free; load wins over read
         if (state_ff.pending && !state_ff.buf_full) begin
            nxt_state.buf_q    = lk.byte_data;
            nxt_state.buf_full = 1'b1;
            nxt_state.pending  = 1'b0;
            nxt_state.take_tgl = ~state_ff.take_tgl;
         end
         if (slave_abort) begin
            nxt_state.pending = 1'b0;
            if (state_ff.pending && !state_ff.buf_full) begin
               nxt_state.buf_q    = state_ff.buf_q;   // keep shown byte unchanged
               nxt_state.buf_full = state_ff.buf_full;
               nxt_state.take_tgl = state_ff.take_tgl;
            end
         end
         if (start_set && !state_ff.start_req) begin
            nxt_state.start_req = 1'b1;
            nxt_state.launched  = 1'b0;
            nxt_state.tbuf_cnt  = 9'h000;
         end
         // count free time, restart on activity
         if (state_ff.start_req && !state_ff.launched) begin
            if (state_ff.busy_s[1]) begin
               nxt_state.tbuf_cnt = 9'h000;
            end else if (state_ff.tbuf_cnt == tbuf_lim - 9'h001) begin
               nxt_state.start_tgl = ~state_ff.start_tgl;
               nxt_state.launched  = 1'b1;
            end else begin
               nxt_state.tbuf_cnt = state_ff.tbuf_cnt + 9'h001;
            end
         end
         if (done_new) begin
            nxt_state.done_seen = state_ff.done_s[1];
            nxt_state.start_req = 1'b0;
         end
         if (!state_ff.ubusy) begin
            if (!state_ff.uart_s[1]) begin
               nxt_state.ubusy = 1'b1;
               nxt_state.ucnt  = 16'h0000;
               nxt_state.ubits = 4'h0;
            end
         end else begin
            if (state_ff.ucnt == 16'(UART_BIT_CYC - 1)) begin
               nxt_state.ucnt  = 16'h0000;
               nxt_state.ubits = state_ff.ubits + 4'h1;
            end else begin
               nxt_state.ucnt = state_ff.ucnt + 16'h0001;
            end
            // mid-bit sampling rejects glitches on the start bit
            if (state_ff.ucnt == 16'(UART_BIT_CYC / 2)) begin
               if (state_ff.ubits == 4'h0 && state_ff.uart_s[1]) begin
                  nxt_state.ubusy = 1'b0;
               end else if (state_ff.ubits == i2c_rx_pkg::UART_STOP_IDX) begin
                  nxt_state.ubusy      = 1'b0;
                  nxt_state.uframe_err = ~state_ff.uart_s[1];
               end
            end
         end
      end
   end

   // single register bank of the system domain
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // carrier toward the link
   assign lk.take_tgl  = state_ff.take_tgl;
   assign lk.start_tgl = state_ff.start_tgl;
   assign lk.abort     = state_ff.abort;
   assign lk.run       = state_ff.run;

   assign i2c_rx_flag      = state_ff.buf_full;
   assign i2c_rx_buffer    = state_ff.buf_q;
   assign scl_low_flag     = state_ff.scll_s[1];
   assign bus_busy_flag    = state_ff.busy_s[1];
   assign start_request    = state_ff.start_req;
   assign uart_busy_flag   = state_ff.ubusy;
   assign uart_frame_error = state_ff.uframe_err;
   assign scl_out          = pin_low;
   assign sda_out          = pin_low;

   rx_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rx_read && state_ff.run && i2c_rx_flag |=> !i2c_rx_flag)
      else $error("read did not free buffer");
   rx_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(i2c_rx_flag) |-> $changed(state_ff.take_tgl) && $past(state_ff.pending))
      else $error("flag rose without a buffered byte");
   scl_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      lk.scl_low [*3] |-> scl_low_flag)
      else $error("clock low not reported");
   tbuf_gap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(state_ff.start_tgl) |-> $past(state_ff.tbuf_cnt) == $past(tbuf_lim) - 9'h001
      && !$past(state_ff.busy_s[1]))
      else $error("start launched before bus free time");
   uart_busy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_ff.run && !soft_reset_bit && !uart_busy_flag && !state_ff.uart_s[1]
      |=> uart_busy_flag)
      else $error("uart busy not set at start bit");
   soft_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      soft_reset_bit |-> ##2 !i2c_rx_flag && !uart_busy_flag && !uart_frame_error
      && !start_request)
      else $error("soft reset left stale state");
   byte_cov_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(i2c_rx_flag) ##[1:200] rx_read);
   start_cov_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(start_request));
   uart_cov_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(uart_busy_flag));
endmodule

// file: tb/i2c_master_model.sv
// Purpose: behavioural two-wire master that sends bytes and samples acks
// Assumes: pull-ups on both lines, device enables active low
// Notes:   waits on a stretched scl without bound, the bench timeout cuts hangs
`timescale 1ns/1ps
module i2c_master_model (
   // device pin enables
   input  wire logic scl_oe_n,
   input  wire logic sda_oe_n,
   // resolved lines
   output logic      scl_line,
   output logic      sda_line
);
   localparam int HALF = 200;
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   // wired and: a released line goes to its pull-up level
   assign scl_line = m_scl & scl_oe_n;
   assign sda_line = m_sda & sda_oe_n;
   // one high phase, held while the device stretches the clock;
   // sampled at its end so an ack driven with the clock release has settled
   task automatic hi_phase(output logic smp);
      m_scl = 1'b1;
      wait (scl_line === 1'b1);
      #HALF smp = sda_line;
      m_scl = 1'b0;
      #HALF;
   endtask
   task automatic start_cond();
      m_sda = 1'b1;
      m_scl = 1'b1;
      #HALF m_sda = 1'b0;
      #HALF m_scl = 1'b0;
      #HALF;
   endtask
   task automatic stop_cond();
      m_sda = 1'b0;
      #HALF m_scl = 1'b1;
      wait (scl_line === 1'b1);
      #HALF m_sda = 1'b1;
      #HALF;
   endtask
   // msb first, data changes only while scl is low
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         m_sda = b[i];
         #HALF hi_phase(s);
      end
      m_sda = 1'b1;
      #HALF hi_phase(ack);
   endtask
endmodule

// file: tb/serial_i2c_receive_start_control_bench.sv
// Purpose: self-checking bench of the i2c receive and start block
// Assumes: uart bit shortened to 8 cycles, bit_clk free running at 32 ns
// Notes:   reset held 8 cycles since the link domain resets through a synced level
`timescale 1ns/1ps
module serial_i2c_receive_start_control_bench;
   localparam int BITC = 8;
   logic       sys_clk = 1'b0;
   logic       bit_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       soft_reset_bit = 1'b0;
   logic       start_set = 1'b0;
   logic       fast_mode = 1'b0;
   logic       slave_abort = 1'b0;
   logic       rx_read = 1'b0;
   logic       uart_rxd = 1'b1;
   logic [7:0] i2c_rx_buffer;
   logic       i2c_rx_flag, scl_low_flag, bus_busy_flag, start_request;
   logic       uart_busy_flag, uart_frame_error, scl_oe_n, sda_oe_n, scl_l, sda_l;
   logic       scl_o, sda_o;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         cyc = 0;
   // clocks of unrelated phase
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      #7;
      forever #16 bit_clk = ~bit_clk;
   end
   i2c_rx_ctrl #(.UART_BIT_CYC(BITC)) i_i2c_rx_ctrl (
      .sys_clk(sys_clk), .reset_n(reset_n), .bit_clk(bit_clk),
      .soft_reset_bit(soft_reset_bit), .start_set(start_set), .fast_mode(fast_mode),
      .slave_abort(slave_abort), .rx_read(rx_read), .i2c_rx_buffer(i2c_rx_buffer),
      .i2c_rx_flag(i2c_rx_flag), .scl_low_flag(scl_low_flag),
      .bus_busy_flag(bus_busy_flag), .start_request(start_request),
      .uart_busy_flag(uart_busy_flag), .uart_frame_error(uart_frame_error),
      .scl_in(scl_l), .sda_in(sda_l), .scl_out(scl_o), .sda_out(sda_o),
      .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .uart_rxd(uart_rxd));
   i2c_master_model i_i2c_master_model (
      .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_line(scl_l), .sda_line(sda_l));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic read_buf(input logic [7:0] exp);
      chk({8'h00, i2c_rx_buffer}, {8'h00, exp});
      rx_read = 1'b1;
      tick(1);
      rx_read = 1'b0;
      // looked at before the next edge: a waiting byte refills the buffer there
      chk(16'(i2c_rx_flag), 16'h0000);
      tick(1);
   endtask
   task automatic rx_two_bytes();
      logic ack;
      chk(16'(scl_low_flag), 16'h0000);
      i_i2c_master_model.start_cond();
      i_i2c_master_model.send_byte(8'hA5, ack);
      tick(20);
      chk({ack, i2c_rx_flag}, 16'h0001);
      fork
         i_i2c_master_model.send_byte(8'h3C, ack);
         begin
            tick(400);
            chk(16'(scl_low_flag), 16'h0001);
            read_buf(8'hA5);
         end
      join
      tick(20);
      chk(16'(ack), 16'h0000);
      read_buf(8'h3C);
   endtask
   task automatic rx_abort();
      logic ack;
      i_i2c_master_model.send_byte(8'h81, ack);
      fork
         i_i2c_master_model.send_byte(8'h7E, ack);
         begin
            tick(400);
            slave_abort = 1'b1;
         end
      join
      chk(16'(ack), 16'h0001);
      tick(1);
      slave_abort = 1'b0;
      i_i2c_master_model.stop_cond();
      tick(20);
      chk(16'(bus_busy_flag), 16'h0000);
      read_buf(8'h81);
   endtask
   task automatic uart_frame(input logic [9:0] f, input int nb);
      for (int i = 0; i < nb; i++) begin
         uart_rxd = f[i];
         tick(BITC);
         if (i == 1) chk(16'(uart_busy_flag), 16'h0001);
      end
      uart_rxd = 1'b1;
   endtask
   task automatic uart_rx();
      uart_frame({1'b0, 8'h55, 1'b0}, 10);
      tick(3 * BITC);
      chk({uart_busy_flag, uart_frame_error}, 16'h0001);
      uart_frame({1'b1, 8'hAA, 1'b0}, 4);
      // no sync mode pin; reset reframes
      soft_reset_bit = 1'b1;
      tick(8);
      chk({uart_busy_flag, uart_frame_error}, 16'h0000);
      soft_reset_bit = 1'b0;
      tick(4 * BITC);
      uart_frame({1'b1, 8'h0F, 1'b0}, 10);
      tick(3 * BITC);
      chk({uart_busy_flag, uart_frame_error}, 16'h0000);
   endtask
   task automatic own_start(input logic fm);
      int         cnt;
      int         ns;
      int         tb_ns;
      time        t_stop;
      tb_ns = fm ? i2c_rx_pkg::T_BUF_FAST_NS : i2c_rx_pkg::T_BUF_STD_NS;
      fast_mode = fm;
      i_i2c_master_model.start_cond();
      tick(20);
      start_set = 1'b1;
      tick(1);
      start_set = 1'b0;
      tick(300);
      chk({start_request, bus_busy_flag, sda_oe_n}, 16'h0007);
      // bus free time runs from the sda rise of the stop on the pins
      fork
         i_i2c_master_model.stop_cond();
         begin
            @(posedge sda_l);
            t_stop = $time;
         end
      join
      cnt = 0;
      while (bus_busy_flag === 1'b1 && cnt < 200) begin
         tick(1);
         cnt++;
      end
      cnt = 0;
      while (sda_oe_n !== 1'b0 && cnt < 1000) begin
         tick(1);
         cnt++;
      end
      ns = int'($time - t_stop);
      chk(16'(ns >= tb_ns && ns <= tb_ns + 400), 16'h0001);
      tick(20);
      chk({start_request, scl_oe_n}, 16'h0000);
      soft_reset_bit = 1'b1;
      tick(8);
      chk({start_request, scl_oe_n}, 16'h0001);
      soft_reset_bit = 1'b0;
      tick(10);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard, far above the few thousand cycles the run needs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         close_out();
      end
   end
   initial begin
      tick(8);
      reset_n = 1'b1;
      tick(10);
      chk({i2c_rx_flag, bus_busy_flag, start_request, uart_busy_flag, scl_o, sda_o},
          16'h0000);
      rx_two_bytes();
      rx_abort();
      uart_rx();
      for (int m = 0; m < 2; m++) own_start(m[0]);
      close_out();
   end
endmodule
